// ===== rtl/alarm_irq_consts.svh
// Purpose: Constants for the E1 alarm and interrupt aggregator
// Assumes: Word offsets are per framer, framer number in upper address bits
// Notes: Offsets follow the in-framer register numbering
`ifndef ALARM_IRQ_CONSTS_SVH
`define ALARM_IRQ_CONSTS_SVH
`define OFF_CRC_TIMER_LOCAL 8'h11
`define OFF_ALARM_REALTIME 8'h12
`define OFF_ALARM_LATCHED 8'h24
`define OFF_TIMER_LATCHED 8'h26
`define OFF_ALARM_PERSIST 8'h27
`define OFF_ALARM_INT 8'h34
`define OFF_TIMER_INT 8'h36
`define OFF_ALARM_MASK 8'h44
`define OFF_TIMER_MASK 8'h46
`define OFF_FRAMER_CTRL 8'hf1
`define OFF_VECTOR_LO 12'h910
`define OFF_VECTOR_HI 12'h911
`define OFF_VMASK_LO 12'h902
`define OFF_VMASK_HI 12'h903
// Alarm bit positions inside alarm registers
`define BIT_REMOTE_ALARM 0
`define BIT_ALL_ONES 1
`define BIT_ALL_ONES_100MS 2
`define BIT_CHAN16_ALL_ONES 3
`define BIT_AUX_PATTERN 4
`define BIT_LOSS_OF_SIGNAL 5
`define BIT_MF_REMOTE_ALARM 6
// Timer bit positions inside timer registers
`define BIT_FIRST_TIMER 0
`define BIT_SECOND_TIMER 1
// Framer control bits
`define BIT_SUSPEND_N 0
`define BIT_CLEAR_ALL_N 1
`define BIT_SOFT_RESET 2
`define BIT_AUTO_RAI_N 3
`define BIT_AUTO_MF_N 4
`define CTRL_RESET 16'h0000
`define MASK_RESET 16'h0000
`define ALARM_LATCH_BITS 16'h007b
`define ALARM_PERSIST_BITS 16'h0023
`define TIMER_BITS 16'h0003
`endif

// ===== rtl/alarm_irq_pkg.sv
// Purpose: Types for the E1 alarm and interrupt aggregator
// Assumes: Eight framers
// Notes: Carriers group per-framer alarm inputs and host bus fields
package alarm_irq_pkg;
  typedef struct packed {
    logic remote_alarm;
    logic all_ones_alarm;
    logic all_ones_100ms;
    logic chan16_all_ones;
    logic auxiliary_pattern;
    logic loss_of_signal;
    logic mf_remote_alarm;
    logic first_timer_event;
    logic second_timer_event;
    logic basic_sync_lost;
    logic multiframe_sync_lost;
  } alarm_in_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [15:0] wdata;
  } host_req_t;
  typedef enum logic [1:0] {
    SRC_ALARM = 2'b00,
    SRC_TIMER = 2'b01
  } src_t;
endpackage

// ===== rtl/e1_alarm_interrupt_aggregator.sv
// Purpose: Alarm status, latching and interrupt aggregation for eight E1 framers
// Assumes: Host reads and writes are one-cycle strobes; read data valid next cycle
// Notes: Address bits 11:8 pick the framer (0..7) or the global page (9)
// Notes: Pin is open-drain; out and oe move together, low only while driven
// Notes: Events are rising edges of the real-time inputs
// Notes: Latched bits are not read-cleared, only clear-all or reset clears them
//
// Function
// - Each alarm except all-ones 100ms has a real-time status bit plus a latched occurrence bit
// - Unmasked interrupt bits latch, request interrupt, clear on host read
// - Persistent bit clears on read only when real-time status is inactive
// - Alarm set mapped per documented real-time, latched, interrupt, persistent bits
// - Auto remote alarm sent while basic sync lost and control bit low
// - Auto multiframe alarm sent while multiframe sync lost and control low
// - Two maskable vectors flag which status registers hold set bits
// - Unmasked vector bits drive pin low, gated by suspend and clear-all
// - Each interrupt status register has a sixteen bit mask register
// - Status clears on read; pin releases once all status clear
// - New events during servicing update status and vector, pin stays low
// - Masked vector bit keeps status working but does not drive pin
// - Suspend low keeps status running but forces framer vector bits zero
// - Clear-all low holds interrupt and latched status cleared, vectors zero
// - Hold-off pin low clears all interrupt status and releases pin
// - Global or framer reset unmasks all and zeroes suspend, clear-all
`timescale 1ns/1ps
`include "alarm_irq_consts.svh"
module e1_alarm_interrupt_aggregator
  import alarm_irq_pkg::*;
#(
  parameter int NUM_FRAMERS = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic global_interrupt_holdoff_n,
  input wire alarm_in_t alarm_in [NUM_FRAMERS],
  input wire host_req_t host_req,
  output logic [15:0] rdata,
  output logic irq_n_out,
  output logic irq_n_oe,
  output logic [NUM_FRAMERS-1:0] send_remote_alarm,
  output logic [NUM_FRAMERS-1:0] send_mf_alarm
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic hit(input host_req_t r, input int f, input logic [7:0] off);
    hit = (r.addr[11:8] == f[3:0]) && (r.addr[7:0] == off);
  endfunction

  // ------------------------------------------------------------
  // Per framer state
  // ------------------------------------------------------------
  logic [15:0] alarm_rt [NUM_FRAMERS];
  logic [15:0] timer_rt [NUM_FRAMERS];
  logic [15:0] alarm_lat_reg [NUM_FRAMERS];
  logic [15:0] alarm_lat_next [NUM_FRAMERS];
  logic [15:0] timer_lat_reg [NUM_FRAMERS];
  logic [15:0] timer_lat_next [NUM_FRAMERS];
  logic [15:0] alarm_per_reg [NUM_FRAMERS];
  logic [15:0] alarm_per_next [NUM_FRAMERS];
  logic [15:0] alarm_int_reg [NUM_FRAMERS];
  logic [15:0] alarm_int_next [NUM_FRAMERS];
  logic [15:0] timer_int_reg [NUM_FRAMERS];
  logic [15:0] timer_int_next [NUM_FRAMERS];
  logic [15:0] alarm_mask_reg [NUM_FRAMERS];
  logic [15:0] alarm_mask_next [NUM_FRAMERS];
  logic [15:0] timer_mask_reg [NUM_FRAMERS];
  logic [15:0] timer_mask_next [NUM_FRAMERS];
  logic [15:0] ctrl_reg [NUM_FRAMERS];
  logic [15:0] ctrl_next [NUM_FRAMERS];
  logic [15:0] alarm_prev_reg [NUM_FRAMERS];
  logic [15:0] timer_prev_reg [NUM_FRAMERS];
  logic [1:0] vec_raw [NUM_FRAMERS];
  logic [15:0] vector;
  logic [15:0] vmask_reg;
  logic [15:0] vmask_next;
  logic [15:0] rdata_next;
  logic irq_active;
  logic [NUM_FRAMERS-1:0] rai_next;
  logic [NUM_FRAMERS-1:0] mf_next;

  genvar g;
  generate
    for (g = 0; g < NUM_FRAMERS; g++) begin : gen_framer
      // ----------------------------------------------------------
      // Real-time view
      // ----------------------------------------------------------
      // Real-time bits follow the receiver directly
      always_comb begin
        alarm_rt[g] = 16'h0000;
        alarm_rt[g][`BIT_REMOTE_ALARM] = alarm_in[g].remote_alarm;
        alarm_rt[g][`BIT_ALL_ONES] = alarm_in[g].all_ones_alarm;
        alarm_rt[g][`BIT_ALL_ONES_100MS] = alarm_in[g].all_ones_100ms;
        alarm_rt[g][`BIT_CHAN16_ALL_ONES] = alarm_in[g].chan16_all_ones;
        alarm_rt[g][`BIT_AUX_PATTERN] = alarm_in[g].auxiliary_pattern;
        alarm_rt[g][`BIT_LOSS_OF_SIGNAL] = alarm_in[g].loss_of_signal;
        alarm_rt[g][`BIT_MF_REMOTE_ALARM] = alarm_in[g].mf_remote_alarm;
        timer_rt[g] = 16'h0000;
        timer_rt[g][`BIT_FIRST_TIMER] = alarm_in[g].first_timer_event;
        timer_rt[g][`BIT_SECOND_TIMER] = alarm_in[g].second_timer_event;
      end

      // ----------------------------------------------------------
      // Occurrence detection and next-state logic
      // ----------------------------------------------------------
      // Set wins over read clear; hold-offs and resets win over set
      logic [15:0] a_rise;
      logic [15:0] t_rise;
      logic rd_a_int;
      logic rd_t_int;
      logic rd_a_per;
      logic soft_rst;
      logic clr_all;
      always_comb begin
        a_rise = alarm_rt[g] & ~alarm_prev_reg[g];
        t_rise = timer_rt[g] & ~timer_prev_reg[g];
        rd_a_int = host_req.rd && hit(host_req, g, `OFF_ALARM_INT);
        rd_t_int = host_req.rd && hit(host_req, g, `OFF_TIMER_INT);
        rd_a_per = host_req.rd && hit(host_req, g, `OFF_ALARM_PERSIST);
        soft_rst = ctrl_reg[g][`BIT_SOFT_RESET];
        clr_all = !ctrl_reg[g][`BIT_CLEAR_ALL_N];
        // Latched bits record occurrences of ALARM_LATCH_BITS and TIMER_BITS; cleared only by clear-all, soft reset or rstn
        alarm_lat_next[g] = alarm_lat_reg[g] | (a_rise & `ALARM_LATCH_BITS);
        timer_lat_next[g] = timer_lat_reg[g] | (t_rise & `TIMER_BITS);
        // Persistent: read clears only bits whose real-time source is idle
        alarm_per_next[g] = alarm_per_reg[g];
        if (rd_a_per) begin
          alarm_per_next[g] = alarm_per_reg[g] & alarm_rt[g];
        end
        alarm_per_next[g] = alarm_per_next[g] | (a_rise & `ALARM_PERSIST_BITS);
        // Set wins over read clear so an event at the read is kept
        alarm_int_next[g] = rd_a_int ? 16'h0000 : alarm_int_reg[g];
        alarm_int_next[g] = alarm_int_next[g] |
                            (a_rise & `ALARM_LATCH_BITS & ~alarm_mask_reg[g]);
        timer_int_next[g] = rd_t_int ? 16'h0000 : timer_int_reg[g];
        timer_int_next[g] = timer_int_next[g] | (t_rise & `TIMER_BITS & ~timer_mask_reg[g]);
        if (clr_all) begin
          alarm_lat_next[g] = 16'h0000;
          timer_lat_next[g] = 16'h0000;
          alarm_int_next[g] = 16'h0000;
          timer_int_next[g] = 16'h0000;
        end
        if (!global_interrupt_holdoff_n) begin
          alarm_int_next[g] = 16'h0000;
          timer_int_next[g] = 16'h0000;
        end
        alarm_mask_next[g] = alarm_mask_reg[g];
        timer_mask_next[g] = timer_mask_reg[g];
        ctrl_next[g] = ctrl_reg[g];
        ctrl_next[g][`BIT_SOFT_RESET] = 1'b0;
        if (host_req.wr && hit(host_req, g, `OFF_ALARM_MASK)) begin
          alarm_mask_next[g] = host_req.wdata;
        end
        if (host_req.wr && hit(host_req, g, `OFF_TIMER_MASK)) begin
          timer_mask_next[g] = host_req.wdata;
        end
        if (host_req.wr && hit(host_req, g, `OFF_FRAMER_CTRL)) begin
          ctrl_next[g] = host_req.wdata;
        end
        if (soft_rst) begin
          alarm_mask_next[g] = `MASK_RESET;
          timer_mask_next[g] = `MASK_RESET;
          ctrl_next[g] = `CTRL_RESET;
          alarm_int_next[g] = 16'h0000;
          timer_int_next[g] = 16'h0000;
          alarm_lat_next[g] = 16'h0000;
          timer_lat_next[g] = 16'h0000;
          alarm_per_next[g] = 16'h0000;
        end
        // Suspend gates the vector, not the status; clear-all gates the vector and clears the status
        vec_raw[g] = 2'b00;
        if (ctrl_reg[g][`BIT_SUSPEND_N] && !clr_all) begin
          vec_raw[g][0] = |alarm_int_reg[g];
          vec_raw[g][1] = |timer_int_reg[g];
        end
        rai_next[g] = !ctrl_reg[g][`BIT_AUTO_RAI_N] && alarm_in[g].basic_sync_lost;
        mf_next[g] = !ctrl_reg[g][`BIT_AUTO_MF_N] && alarm_in[g].multiframe_sync_lost;
      end

      // ----------------------------------------------------------
      // Status registers: latched, persistent, interrupt
      // ----------------------------------------------------------
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          alarm_lat_reg[g] <= 16'h0000;
          timer_lat_reg[g] <= 16'h0000;
          alarm_per_reg[g] <= 16'h0000;
          alarm_int_reg[g] <= 16'h0000;
          timer_int_reg[g] <= 16'h0000;
        end else begin
          alarm_lat_reg[g] <= alarm_lat_next[g];
          timer_lat_reg[g] <= timer_lat_next[g];
          alarm_per_reg[g] <= alarm_per_next[g];
          alarm_int_reg[g] <= alarm_int_next[g];
          timer_int_reg[g] <= timer_int_next[g];
        end
      end

      // ----------------------------------------------------------
      // Configuration registers: masks and framer control
      // ----------------------------------------------------------
      // Masks reset to zero, so every status bit starts unmasked
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          alarm_mask_reg[g] <= `MASK_RESET;
          timer_mask_reg[g] <= `MASK_RESET;
          ctrl_reg[g] <= `CTRL_RESET;
        end else begin
          alarm_mask_reg[g] <= alarm_mask_next[g];
          timer_mask_reg[g] <= timer_mask_next[g];
          ctrl_reg[g] <= ctrl_next[g];
        end
      end

      // ----------------------------------------------------------
      // Edge history of the real-time inputs
      // ----------------------------------------------------------
      // History resets idle, so an input already high at release
      // counts as an occurrence on the first edge
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          alarm_prev_reg[g] <= 16'h0000;
          timer_prev_reg[g] <= 16'h0000;
        end else begin
          alarm_prev_reg[g] <= alarm_rt[g];
          timer_prev_reg[g] <= timer_rt[g];
        end
      end

      // ----------------------------------------------------------
      // Vector bits of this framer
      // ----------------------------------------------------------
      assign vector[2*g] = vec_raw[g][0];
      assign vector[2*g+1] = vec_raw[g][1];
    end
  endgenerate

  // ------------------------------------------------------------
  // Vector, pin and read mux
  // ------------------------------------------------------------
  always_comb begin
    // Pin follows vector bits gated by hold-off; mask bit high lets a vector bit through
    irq_active = |(vector & vmask_reg) && global_interrupt_holdoff_n;
    vmask_next = vmask_reg;
    if (host_req.wr && host_req.addr == `OFF_VMASK_LO) begin
      vmask_next = host_req.wdata;
    end
    rdata_next = 16'h0000;
    if (host_req.rd) begin
      if (host_req.addr == `OFF_VECTOR_LO) begin
        rdata_next = {8'h00, vector[7:0]};
      end else if (host_req.addr == `OFF_VECTOR_HI) begin
        rdata_next = {8'h00, vector[15:8]};
      end else if (host_req.addr == `OFF_VMASK_LO) begin
        rdata_next = vmask_reg;
      end
      for (int f = 0; f < NUM_FRAMERS; f++) begin
        if (hit(host_req, f, `OFF_CRC_TIMER_LOCAL)) rdata_next = timer_rt[f];
        if (hit(host_req, f, `OFF_ALARM_REALTIME)) rdata_next = alarm_rt[f];
        if (hit(host_req, f, `OFF_ALARM_LATCHED)) rdata_next = alarm_lat_reg[f];
        if (hit(host_req, f, `OFF_TIMER_LATCHED)) rdata_next = timer_lat_reg[f];
        if (hit(host_req, f, `OFF_ALARM_PERSIST)) rdata_next = alarm_per_reg[f];
        if (hit(host_req, f, `OFF_ALARM_INT)) rdata_next = alarm_int_reg[f];
        if (hit(host_req, f, `OFF_TIMER_INT)) rdata_next = timer_int_reg[f];
        if (hit(host_req, f, `OFF_ALARM_MASK)) rdata_next = alarm_mask_reg[f];
        if (hit(host_req, f, `OFF_TIMER_MASK)) rdata_next = timer_mask_reg[f];
        if (hit(host_req, f, `OFF_FRAMER_CTRL)) rdata_next = ctrl_reg[f];
      end
    end
  end

  // ------------------------------------------------------------
  // Output and global registers
  // ------------------------------------------------------------
  // Vector mask resets open so unmasked status can reach the pin
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vmask_reg <= 16'hffff;
      rdata <= 16'h0000;
      irq_n_out <= 1'b1;
      irq_n_oe <= 1'b1;
      send_remote_alarm <= '0;
      send_mf_alarm <= '0;
    end else begin
      vmask_reg <= vmask_next;
      rdata <= rdata_next;
      // Open-drain: drive low only while active, else released
      irq_n_out <= !irq_active;
      irq_n_oe <= !irq_active;
      send_remote_alarm <= rai_next;
      send_mf_alarm <= mf_next;
    end
  end

endmodule

// ===== bench/host_irq_model.sv
// Purpose: Host-side view of the interrupt pin
// Assumes: Board pull-up on the pin
// Notes: Released pin reads high, never the last driven value
`timescale 1ns/1ps
module host_irq_model (
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  output logic irq_line
);
  // Pull-up wins whenever the device lets go
  assign irq_line = irq_n_oe ? 1'b1 : irq_n_out;
endmodule

// ===== bench/e1_alarm_irq_assertions.sv
// Purpose: Port-level checks of the alarm interrupt aggregator
// Assumes: Only top ports visible, framer 0 stands for the rest
// Notes: Control state is unseen, so checks avoid depending on it
`timescale 1ns/1ps
module e1_alarm_irq_checker
  import alarm_irq_pkg::*;
#(
  parameter int NUM_FRAMERS = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic global_interrupt_holdoff_n,
  input wire alarm_in_t alarm_in [NUM_FRAMERS],
  input wire host_req_t host_req,
  input wire logic [15:0] rdata,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic [NUM_FRAMERS-1:0] send_remote_alarm,
  input wire logic [NUM_FRAMERS-1:0] send_mf_alarm
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_int_rd;
    host_req.rd && host_req.addr == 12'h034 && $stable(alarm_in[0]);
  endsequence
  sequence s_int_rd_twice;
    s_int_rd ##1 s_int_rd;
  endsequence
  property p_int_read_clear;
    s_int_rd_twice |=> (rdata & 16'h007b) == 16'h0000;
  endproperty
  property p_pin_pair;
    irq_n_out == irq_n_oe;
  endproperty
  property p_holdoff_release;
    !global_interrupt_holdoff_n [*2] |-> irq_n_oe;
  endproperty
  property p_fall_cause;
    $fell(irq_n_oe) |-> $past(global_interrupt_holdoff_n) && $past(global_interrupt_holdoff_n, 2);
  endproperty
  property p_reset_quiet;
    $rose(rstn) |-> irq_n_oe [*2];
  endproperty
  property p_rdata_idle;
    !host_req.rd |=> rdata == 16'h0000;
  endproperty
  property p_rai_stop;
    !alarm_in[0].basic_sync_lost |=> !send_remote_alarm[0];
  endproperty
  property p_mf_stop;
    !alarm_in[0].multiframe_sync_lost |=> !send_mf_alarm[0];
  endproperty
  a_int_read_clear: assert property (p_int_read_clear) else $error("read did not clear");
  a_pin_pair: assert property (p_pin_pair) else $error("pin drive pair split");
  a_holdoff_release: assert property (p_holdoff_release) else $error("pin held in holdoff");
  a_fall_cause: assert property (p_fall_cause) else $error("pin fell during holdoff");
  a_reset_quiet: assert property (p_reset_quiet) else $error("pin low after reset");
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata without read");
  a_rai_stop: assert property (p_rai_stop) else $error("remote alarm kept");
  a_mf_stop: assert property (p_mf_stop) else $error("multiframe alarm kept");
endmodule

bind e1_alarm_interrupt_aggregator e1_alarm_irq_checker #(.NUM_FRAMERS(NUM_FRAMERS)) u_chk (
  .mclk(mclk), .rstn(rstn), .global_interrupt_holdoff_n(global_interrupt_holdoff_n),
  .alarm_in(alarm_in), .host_req(host_req), .rdata(rdata), .irq_n_out(irq_n_out),
  .irq_n_oe(irq_n_oe), .send_remote_alarm(send_remote_alarm), .send_mf_alarm(send_mf_alarm));

// ===== bench/tb_e1_alarm_interrupt_aggregator.sv
// Purpose: Register-level tests of the alarm interrupt aggregator
// Assumes: Inputs change at the falling edge, rdata stands one cycle
// Notes: Pin checked three edges after its cause
`timescale 1ns/1ps
module tb_e1_alarm_interrupt_aggregator;
  import alarm_irq_pkg::*;
  logic mclk;
  logic rstn;
  logic holdoff_n;
  alarm_in_t ain [8];
  host_req_t h;
  logic [15:0] rdata;
  logic irq_n_out;
  logic irq_n_oe;
  logic irq_line;
  logic [7:0] send_rai;
  logic [7:0] send_mf;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  e1_alarm_interrupt_aggregator #(.NUM_FRAMERS(8)) u_dut (.mclk(mclk), .rstn(rstn),
    .global_interrupt_holdoff_n(holdoff_n), .alarm_in(ain), .host_req(h), .rdata(rdata),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .send_remote_alarm(send_rai),
    .send_mf_alarm(send_mf));
  host_irq_model u_host (.irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_line(irq_line));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    h.wr = 1'b1;
    h.addr = a;
    h.wdata = d;
    @(negedge mclk);
    h.wr = 1'b0;
    @(negedge mclk);
  endtask
  // Twice keeps rd high for a back-to-back second read
  task automatic rd(input logic [11:0] a, input logic [15:0] m, input logic [15:0] e,
                    input logic [15:0] e2 = 16'h0000, input bit twice = 1'b0);
    h.rd = 1'b1;
    h.addr = a;
    @(negedge mclk);
    h.rd = twice;
    chk16(rdata & m, e);
    if (twice) begin
      @(negedge mclk);
      h.rd = 1'b0;
      chk16(rdata & m, e2);
    end
    @(negedge mclk);
  endtask
  task automatic pin(input logic e);
    repeat (3) @(negedge mclk);
    chk16({15'h0000, irq_line}, {15'h0000, e});
  endtask
  task automatic sync_lost(input logic v);
    ain[0].basic_sync_lost = v;
    ain[0].multiframe_sync_lost = v;
    repeat (2) @(negedge mclk);
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    holdoff_n = 1'b1;
    h = '0;
    foreach (ain[i]) ain[i] = '0;
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    rd(12'h0f1, 16'h001f, 16'h0000);
    rd(12'h902, 16'hffff, 16'hffff);
    ain[0].remote_alarm = 1'b1;
    pin(1'b1);
    rd(12'h034, 16'h007b, 16'h0000);
    ain[0].remote_alarm = 1'b0;
    wr(12'h0f1, 16'h0003);
    sync_lost(1'b1);
    chk16({14'h0000, send_mf[0], send_rai[0]}, 16'h0003);
    sync_lost(1'b0);
    chk16({14'h0000, send_mf[0], send_rai[0]}, 16'h0000);
    wr(12'h0f1, 16'h001b);
    sync_lost(1'b1);
    chk16({14'h0000, send_mf[0], send_rai[0]}, 16'h0000);
    sync_lost(1'b0);
    ain[0].remote_alarm = 1'b1;
    ain[0].all_ones_100ms = 1'b1;
    pin(1'b0);
    rd(12'h012, 16'h0005, 16'h0005);
    rd(12'h024, 16'h0005, 16'h0001);
    rd(12'h910, 16'h0003, 16'h0001);
    rd(12'h034, 16'h007b, 16'h0001, 16'h0000, 1'b1);
    pin(1'b1);
    rd(12'h027, 16'h0023, 16'h0001, 16'h0001, 1'b1);
    ain[0].remote_alarm = 1'b0;
    rd(12'h027, 16'h0023, 16'h0001, 16'h0000, 1'b1);
    ain[0].remote_alarm = 1'b1;
    ain[0].first_timer_event = 1'b1;
    pin(1'b0);
    rd(12'h034, 16'h007b, 16'h0001);
    pin(1'b0);
    rd(12'h036, 16'h0003, 16'h0001, 16'h0000, 1'b1);
    pin(1'b1);
    rd(12'h011, 16'h0003, 16'h0001);
    rd(12'h026, 16'h0003, 16'h0001);
    wr(12'h902, 16'hfffe);
    ain[0].all_ones_alarm = 1'b1;
    pin(1'b1);
    rd(12'h034, 16'h007b, 16'h0002);
    wr(12'h902, 16'hffff);
    wr(12'h0f1, 16'h001a);
    ain[0].auxiliary_pattern = 1'b1;
    pin(1'b1);
    rd(12'h910, 16'h0003, 16'h0000);
    rd(12'h034, 16'h007b, 16'h0010);
    wr(12'h0f1, 16'h0019);
    ain[0].loss_of_signal = 1'b1;
    pin(1'b1);
    rd(12'h024, 16'h007b, 16'h0000);
    rd(12'h034, 16'h007b, 16'h0000);
    wr(12'h0f1, 16'h001b);
    wr(12'h044, 16'h0040);
    holdoff_n = 1'b0;
    ain[0].chan16_all_ones = 1'b1;
    pin(1'b1);
    rd(12'h034, 16'h007b, 16'h0000);
    rd(12'h044, 16'hffff, 16'h0040);
    holdoff_n = 1'b1;
    ain[0].mf_remote_alarm = 1'b1;
    rd(12'h034, 16'h007b, 16'h0000, 16'h0000, 1'b1);
    wr(12'h0f1, 16'h001f);
    rd(12'h0f1, 16'h001f, 16'h0000);
    rd(12'h044, 16'hffff, 16'h0000);
    print_verdict();
  end
endmodule
